// ---- hdl/uefs_defines.vh ----
// register map, field positions and reset values of the endpoint block
`ifndef UEFS_DEFINES_VH
`define UEFS_DEFINES_VH
`define UEFS_ADDR_CFG 32'h4002_0100
`define UEFS_ADDR_DATA 32'h4002_0104
`define UEFS_ADDR_CTRL 32'h4002_0108
`define UEFS_ADDR_STAT 32'h4002_0130
`define UEFS_ADDR_CLR 32'h4002_0160
`define UEFS_ADDR_SET 32'h4002_0190
`define UEFS_CFG_DIR 0
`define UEFS_CFG_TYPE_LO 1
`define UEFS_CFG_BANKS_LO 3
`define UEFS_CFG_SIZE_LO 5
`define UEFS_CFG_MEMORY_ALLOCATE_BIT 8
`define UEFS_CFG_NBE 12
`define UEFS_CFG_RESET 13'h0000
`define UEFS_CTRL_RELEASE 14
`define UEFS_NB_BIT 12
`define UEFS_ST_TOG_LO 8
`define UEFS_ST_NBF 11
`define UEFS_ST_NB_LO 12
`define UEFS_ST_CUR_LO 14
`define UEFS_ST_ACCESS_ALLOWED_FLAG 16
`define UEFS_ST_CONFIG_VALID_FLAG 18
`define UEFS_ST_BANK_BYTE_COUNTER_LO 20
`define UEFS_TOG_RESET 1'b1
`define UEFS_TYPE_ISO 2'h1
`define UEFS_ISO_UNUSED 8'h18
`define UEFS_HTRANS_NONSEQ 2'h2
`define UEFS_MIN_SIZE 7'h08
`endif

// ---- hdl/uefs_endpoint.v ----
// one usb device endpoint: banks, byte counts, toggle and status flags
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
// Summary of operation
// - toggle field: 0 DATA0, 1 DATA1
// - IN: toggle names next packet to send
// - OUT: toggle is last received in bank
// - toggle reads 0b01 after reset
// - IN busy count: filled banks awaiting send
// - OUT busy count: received, unreleased banks
// - busy-bank irq on all free/all busy
// - busy count updates after bank release
// - current bank field 0, 1 or 2
// - bank and count may lag flag
// - IN: access allowed while bank not full
// - OUT: access allowed while bank not empty
// - access flag never set on error
// - config valid only if banks fit memory
// - IN byte count: up on write, down on send
// - OUT byte count: up on receive, down on read
// - clear view: one clears, zero nothing
// - clear and set views read zero
// - control layout flags in bits 0..7
// - iso layout: bits 3 and 4 unused
// - set view: one forces flag
// - set view bit 12 forces busy irq
// - release advances current bank pointer
`include "uefs_defines.vh"
module uefs_endpoint #(
  parameter MAX_BANKS = 3,
  parameter MAX_SIZE = 64,
  parameter MEM_BYTES = 192
) (
  input wire CLK,
  input wire RST_N,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  output wire [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  input wire USB_TX_REQ,
  output wire [7:0] USB_TX_DATA,
  input wire USB_RX_VALID,
  input wire [7:0] USB_RX_DATA,
  input wire USB_PKT_ACK,
  input wire USB_RX_TOGGLE,
  input wire [7:0] USB_EVENT,
  input wire USB_ERROR,
  output wire EP_BANK_READY,
  output wire EP_IRQ
);

  // ****************************************
  // reset release
  // ****************************************
  reg [1:0] rst_sync_q;
  wire rst_n;
  // async assert, two-flop release so no flop sees a runt reset edge
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // state
  // ****************************************
  reg [12:0] cfg_q;
  reg config_valid_flag_q;
  wire [2:0] busy_q;
  reg [1:0] cur_q;
  reg [1:0] usb_q;
  reg [5:0] sw_idx_q;
  reg [5:0] usb_idx_q;
  reg tog_q;
  reg [2:0] btog_q;
  wire [7:0] flag_q;
  reg nbf_q;
  reg [1:0] rel_q;
  reg [7:0] mem [0:255];
  reg [7:0] tx_data_q;
  reg [31:0] hrdata_q;
  reg wr_q;
  reg [31:0] waddr_q;
  wire [6:0] bc [0:2];
  wire [2:0] busy_d;

  wire dir_in = cfg_q[`UEFS_CFG_DIR];
  wire [1:0] ep_type = cfg_q[`UEFS_CFG_TYPE_LO +: 2];
  wire is_iso = (ep_type == `UEFS_TYPE_ISO);
  wire [1:0] nbank_set = cfg_q[`UEFS_CFG_BANKS_LO +: 2];
  wire [2:0] size_code = cfg_q[`UEFS_CFG_SIZE_LO +: 3];
  wire [6:0] ep_size = `UEFS_MIN_SIZE << size_code[1:0];
  // pointers wrap before the reserved value 3
  wire [1:0] last_bank = (nbank_set > 2'd2) ? 2'd2 : nbank_set;
  wire [1:0] cur_next = (cur_q == last_bank) ? 2'd0 : cur_q + 2'd1;
  wire [1:0] usb_next = (usb_q == last_bank) ? 2'd0 : usb_q + 2'd1;

  // ****************************************
  // bus slave
  // ****************************************
  wire acc = HSEL && HREADY && (HTRANS == `UEFS_HTRANS_NONSEQ);
  wire rd_acc = acc && !HWRITE;
  wire wr_cfg = wr_q && (waddr_q == `UEFS_ADDR_CFG);
  wire wr_data = wr_q && (waddr_q == `UEFS_ADDR_DATA);
  wire wr_ctrl = wr_q && (waddr_q == `UEFS_ADDR_CTRL);
  wire wr_clr = wr_q && (waddr_q == `UEFS_ADDR_CLR);
  wire wr_set = wr_q && (waddr_q == `UEFS_ADDR_SET);
  wire rd_data = rd_acc && (HADDR == `UEFS_ADDR_DATA);

  // zero-wait slave, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_q;

  // address phase capture for the following data phase
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      waddr_q <= 32'h0000_0000;
    end else if (HREADY) begin
      wr_q <= acc && HWRITE;
      waddr_q <= HADDR;
    end
  end

  // ****************************************
  // access flag and status word
  // ****************************************
  wire [6:0] cur_cnt = bc[cur_q];
  wire [1:0] nbusy = {1'b0, busy_q[0]} + {1'b0, busy_q[1]}
                     + {1'b0, busy_q[2]};
  wire [1:0] nbusy_d = {1'b0, busy_d[0]} + {1'b0, busy_d[1]}
                       + {1'b0, busy_d[2]};
  wire [1:0] nbank_m1 = last_bank;
  wire in_room = !busy_q[cur_q] && (cur_cnt < ep_size);
  wire out_left = busy_q[cur_q] && (cur_cnt != 7'd0);
  wire access_allowed_flag = !USB_ERROR && config_valid_flag_q && (dir_in ? in_room : out_left);
  wire tog_view = dir_in ? tog_q : btog_q[cur_q];
  // bank and count read from flops, never ahead of flag
  wire [31:0] status;
  assign status = {1'b0, 4'h0, cur_cnt, 1'b0, config_valid_flag_q, 1'b0, access_allowed_flag,
                   cur_q, nbusy, nbf_q, 1'b0, 1'b0, tog_view, flag_q};

  // read data from flops; clear and set views read zero
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (HADDR)
        `UEFS_ADDR_CFG: hrdata_q <= {19'h0_0000, cfg_q};
        `UEFS_ADDR_STAT: hrdata_q <= status;
        `UEFS_ADDR_DATA: hrdata_q <= {24'h00_0000,
                                      mem[{cur_q, sw_idx_q}]};
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  wire [8:0] need = {2'b00, ep_size} * {7'h00, last_bank + 2'd1};
  // fit check against bank limit, size and memory
  wire fits = (size_code < 3'd4) && ({1'b0, last_bank} < MAX_BANKS)
              && (ep_size <= MAX_SIZE) && (need <= MEM_BYTES)
              && (nbank_set < 2'd3);
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `UEFS_CFG_RESET;
      config_valid_flag_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= HWDATA[12:0];
      end
      if (cfg_q[`UEFS_CFG_MEMORY_ALLOCATE_BIT]) begin
        config_valid_flag_q <= fits;
      end
    end
  end

  // ****************************************
  // bank release pipeline
  // ****************************************
  wire rel_req = wr_ctrl && HWDATA[`UEFS_CTRL_RELEASE];
  wire rel_do = rel_q[1];
  // bank state moves two edges after the write lands
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rel_q <= 2'b00;
    end else begin
      rel_q <= {rel_q[0], rel_req};
    end
  end

  // ****************************************
  // software and usb byte strobes
  // ****************************************
  wire sw_wr = wr_data && dir_in && in_room;
  wire sw_rd = rd_data && !dir_in && out_left;
  wire usb_tx = USB_TX_REQ && dir_in && busy_q[usb_q] && (bc[usb_q] != 7'd0);
  wire usb_rx = USB_RX_VALID && !dir_in && !busy_q[usb_q]
                && (bc[usb_q] < ep_size);
  wire ack_in = USB_PKT_ACK && dir_in && busy_q[usb_q];
  wire ack_out = USB_PKT_ACK && !dir_in && !busy_q[usb_q];

  // ready toward the protocol engine: IN has data, OUT has room
  assign EP_BANK_READY = config_valid_flag_q && (dir_in ? busy_q[usb_q]
                                            : !busy_q[usb_q]);

  // ****************************************
  // per bank busy bit and byte counter
  // ****************************************
  genvar b;
  generate
    for (b = 0; b < 3; b = b + 1) begin : g_bank
      localparam [1:0] BANK_ID = b;
      reg [6:0] cnt_q;
      reg bz_q;
      wire cur_hit = (cur_q == BANK_ID);
      wire usb_hit = (usb_q == BANK_ID);
      wire inc = (sw_wr && cur_hit) || (usb_rx && usb_hit);
      wire dec = (sw_rd && cur_hit) || (usb_tx && usb_hit);
      wire set_b = (rel_do && dir_in && cur_hit)
                   || (ack_out && usb_hit);
      wire clr_b = (rel_do && !dir_in && cur_hit)
                   || (ack_in && usb_hit);
      wire zap = rel_do && !dir_in && cur_hit;
      assign busy_d[b] = set_b ? 1'b1 : (clr_b ? 1'b0 : bz_q);
      assign bc[b] = cnt_q;
      assign busy_q[b] = bz_q;
      always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          cnt_q <= 7'd0;
          bz_q <= 1'b0;
        end else begin
          bz_q <= busy_d[b];
          if (zap) begin
            cnt_q <= 7'd0;
          end else if (inc && !dec) begin
            cnt_q <= cnt_q + 7'd1;
          end else if (dec && !inc) begin
            cnt_q <= cnt_q - 7'd1;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // bank pointers, packet memory and toggle
  // ****************************************
  always @(posedge CLK) begin
    if (sw_wr) begin
      mem[{cur_q, sw_idx_q}] <= HWDATA[7:0];
    end else if (usb_rx) begin
      mem[{usb_q, usb_idx_q}] <= USB_RX_DATA;
    end
  end
  assign USB_TX_DATA = tx_data_q;

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= 2'd0;
      usb_q <= 2'd0;
      sw_idx_q <= 6'd0;
      usb_idx_q <= 6'd0;
      tx_data_q <= 8'h00;
      tog_q <= `UEFS_TOG_RESET;
      btog_q <= {3{`UEFS_TOG_RESET}};
    end else begin
      // release moves software to next bank
      if (rel_do) begin
        cur_q <= cur_next;
        sw_idx_q <= 6'd0;
      end else if (sw_wr || sw_rd) begin
        sw_idx_q <= sw_idx_q + 6'd1;
      end
      if (usb_tx) begin
        tx_data_q <= mem[{usb_q, usb_idx_q}];
      end
      if (ack_in || ack_out) begin
        usb_q <= usb_next;
        usb_idx_q <= 6'd0;
      end else if (usb_tx || usb_rx) begin
        usb_idx_q <= usb_idx_q + 6'd1;
      end
      if (ack_in && !is_iso) begin
        tog_q <= !tog_q;
      end
      if (ack_out) begin
        btog_q[usb_q] <= USB_RX_TOGGLE;
        tog_q <= USB_RX_TOGGLE;
      end
    end
  end

  // ****************************************
  // endpoint status flags
  // ****************************************
  // control layout uses all eight bits
  // iso layout leaves bits 3 and 4 dead
  wire [7:0] live = is_iso ? ~`UEFS_ISO_UNUSED : 8'hff;
  wire [7:0] clr_m = wr_clr ? (HWDATA[7:0] & live) : 8'h00;
  wire [7:0] set_m = wr_set ? (HWDATA[7:0] & live) : 8'h00;
  wire [7:0] hw_m = USB_EVENT & live;

  genvar f;
  generate
    for (f = 0; f < 8; f = f + 1) begin : g_flag
      reg fl_q;
      // hardware and forced sets win over a clear
      always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          fl_q <= 1'b0;
        end else if (hw_m[f] || set_m[f]) begin
          fl_q <= 1'b1;
        end else if (clr_m[f]) begin
          fl_q <= 1'b0;
        end
      end
      assign flag_q[f] = fl_q;
    end
  endgenerate

  // ****************************************
  // busy bank interrupt
  // ****************************************
  // IN: last bank drained; OUT: last bank filled
  wire nb_evt = dir_in ? (nbusy != 2'd0 && nbusy_d == 2'd0)
                       : (nbusy != nbank_m1 + 2'd1
                          && nbusy_d == nbank_m1 + 2'd1);
  // set view bit forces the flag
  wire nb_set = nb_evt || (wr_set && HWDATA[`UEFS_NB_BIT]);
  wire nb_clr = wr_clr && HWDATA[`UEFS_NB_BIT];
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      nbf_q <= 1'b0;
    end else if (nb_set) begin
      nbf_q <= 1'b1;
    end else if (nb_clr) begin
      nbf_q <= 1'b0;
    end
  end
  assign EP_IRQ = nbf_q && cfg_q[`UEFS_CFG_NBE];

endmodule

// ---- tb/uefs_endpoint_assertions.sv ----
// concurrent checks on the endpoint block ports
`timescale 1ns/1ns
`include "uefs_defines.vh"
module uefs_endpoint_chk (
  input wire CLK,
  input wire RST_N,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  input wire [31:0] HRDATA,
  input wire [7:0] USB_EVENT,
  input wire USB_ERROR,
  input wire EP_IRQ
);
  // ****************
  // helper logic
  // ****************
  wire take = HSEL && HREADY && HTRANS == `UEFS_HTRANS_NONSEQ;
  wire rd = take && !HWRITE;
  reg cw_q;
  reg en_q;
  // shadow of the busy irq enable, since it is not visible at a port
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cw_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      cw_q <= take && HWRITE && HADDR == `UEFS_ADDR_CFG;
      if (cw_q)
        en_q <= HWDATA[`UEFS_CFG_NBE];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd_stat;
    rd && HADDR == `UEFS_ADDR_STAT;
  endsequence
  sequence s_force;
    take && HWRITE && HADDR == `UEFS_ADDR_SET ##1 HWDATA[12] && en_q;
  endsequence
  // ****************
  // properties
  // ****************
  chk_views_zero: assert property (
    rd && (HADDR == `UEFS_ADDR_CLR || HADDR == `UEFS_ADDR_SET)
    |=> HRDATA == 32'h0) else $error("flag view read not zero");
  chk_toggle_legal: assert property (s_rd_stat |=> !HRDATA[9])
    else $error("toggle reserved value");
  chk_bank_legal: assert property (
    s_rd_stat |=> HRDATA[15:14] != 2'd3) else $error("bank reserved value");
  chk_error_blocks: assert property (
    USB_ERROR [*2] ##0 s_rd_stat |=> !HRDATA[16])
    else $error("access allowed in error");
  chk_event_sets: assert property (
    USB_EVENT[6] ##1 s_rd_stat |=> HRDATA[6]) else $error("event lost");
  chk_data_stands: assert property (!rd |=> $stable(HRDATA))
    else $error("read data moved");
  chk_irq_enabled: assert property (EP_IRQ |-> en_q)
    else $error("irq without enable");
  chk_irq_forced: assert property (s_force |-> ##[1:2] EP_IRQ)
    else $error("forced irq missing");
endmodule
bind uefs_endpoint uefs_endpoint_chk chk_u (.CLK(CLK), .RST_N(RST_N),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
  .USB_EVENT(USB_EVENT), .USB_ERROR(USB_ERROR), .EP_IRQ(EP_IRQ));

// ---- tb/uefs_host_model.sv ----
// usb host side model driving the endpoint link strobes
`timescale 1ns/1ns
module uefs_host_model (
  input wire clk,
  output logic tx_req,
  input wire [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic pkt_ack,
  output logic rx_toggle,
  output logic [7:0] event_pulse,
  output logic err
);
  logic [7:0] got [0:7];
  // idle link: no strobes, data lines parked
  initial begin
    {tx_req, rx_valid, pkt_ack, rx_toggle, err} = 5'h00;
    rx_data = 8'h5a;
    event_pulse = 8'h00;
  end
  // out packet; the released data line shows the inverse, not the last byte
  task automatic send_out(input logic [7:0] b, input int n, input logic t);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= b + 8'(i);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    pkt_ack <= 1'b1;
    rx_toggle <= t;
    @(posedge clk);
    pkt_ack <= 1'b0;
    rx_toggle <= ~t;
  endtask
  // in packet; each byte shows the cycle after its request is taken
  task automatic take_in(input int n);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge clk);
      if (i > 1)
        got[i - 2] = tx_data;
      tx_req <= i < n;
    end
    @(posedge clk);
    pkt_ack <= 1'b1;
    @(posedge clk);
    pkt_ack <= 1'b0;
  endtask
  // error level; caller sits just after an edge, so no race with sampling
  task automatic fault(input logic v);
    err <= v;
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    event_pulse <= m;
    @(posedge clk);
    event_pulse <= 8'h00;
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the endpoint status block
`timescale 1ns/1ns
`include "uefs_defines.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  num_errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  logic clk, rst_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, r;
  logic [1:0] htrans;
  wire [31:0] hrdata;
  wire hready, hresp, tx_req, rx_valid, pkt_ack, rx_tog, err, irq, bk_rdy;
  wire [7:0] tx_data, rx_data, evt;
  int num_errors, comparisons;
  uefs_endpoint dut_u (.CLK(clk), .RST_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .USB_TX_REQ(tx_req),
    .USB_TX_DATA(tx_data), .USB_RX_VALID(rx_valid), .USB_RX_DATA(rx_data),
    .USB_PKT_ACK(pkt_ack), .USB_RX_TOGGLE(rx_tog), .USB_EVENT(evt),
    .USB_ERROR(err), .EP_BANK_READY(bk_rdy), .EP_IRQ(irq));
  uefs_host_model host_u (.clk(clk), .tx_req(tx_req), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .pkt_ack(pkt_ack),
    .rx_toggle(rx_tog), .event_pulse(evt), .err(err));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************
  // bus and reset
  // ****************
  // word transfer: address held until ready, then data until ready
  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `UEFS_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge clk);
    ahb(`UEFS_ADDR_STAT, 1'b0, 32'h0);
  endtask
  // the design's reset copy needs two edges, so wait three before traffic
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    do_reset();
    st(0);
    `CHK("toggle", 2'b01, r[9:8])
    `CHK("busy", 2'd0, r[13:12])
    ahb(`UEFS_ADDR_CLR, 1'b1, 32'hffff_ffff);
    ahb(`UEFS_ADDR_CLR, 1'b0, 32'h0);
    `CHK("clr view", 32'h0, r)
    ahb(`UEFS_ADDR_SET, 1'b0, 32'h0);
    `CHK("set view", 32'h0, r)
    ahb(32'h4002_0ffc, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, r)
    `CHK("resp okay", 1'b0, hresp)
    ahb(`UEFS_ADDR_CFG, 1'b1, 32'h0000_011d);
    st(2);
    `CHK("cfg bad", 1'b0, r[18])
    ahb(`UEFS_ADDR_CFG, 1'b1, 32'h0000_110d);
    st(2);
    `CHK("cfg good", 1'b1, r[18])
  endtask
  task automatic t_in;
    do_reset();
    ahb(`UEFS_ADDR_CFG, 1'b1, 32'h0000_110d);
    st(2);
    `CHK("in room", 1'b1, r[16])
    for (int i = 0; i < 3; i++)
      ahb(`UEFS_ADDR_DATA, 1'b1, 32'h0000_00a0 + i);
    st(1);
    `CHK("in count", 7'd3, r[26:20])
    ahb(`UEFS_ADDR_CTRL, 1'b1, 32'h0000_4000);
    st(0);
    `CHK("busy early", 2'd0, r[13:12])
    st(0);
    `CHK("busy late", 2'd1, r[13:12])
    `CHK("cur bank", 2'd1, r[15:14])
    `CHK("bank ready", 1'b1, bk_rdy)
    host_u.take_in(3);
    for (int i = 0; i < 3; i++)
      `CHK("tx byte", 8'ha0 + i[7:0], host_u.got[i])
    st(2);
    `CHK("busy done", 2'd0, r[13:12])
    `CHK("toggle", 2'b00, r[9:8])
    `CHK("irq free", 1'b1, irq)
  endtask
  task automatic t_force;
    do_reset();
    ahb(`UEFS_ADDR_CFG, 1'b1, 32'h0000_1104);
    ahb(`UEFS_ADDR_SET, 1'b1, 32'h0000_10ff);
    st(1);
    `CHK("forced", 8'hff, r[7:0])
    `CHK("irq set", 1'b1, irq)
    ahb(`UEFS_ADDR_CLR, 1'b1, 32'h0);
    st(1);
    `CHK("clr zero", 8'hff, r[7:0])
    fork
      ahb(`UEFS_ADDR_CLR, 1'b1, 32'h0000_10ff);
      host_u.pulse(8'h40);
    join
    st(0);
    `CHK("set wins", 8'h40, r[7:0])
    `CHK("irq clr", 1'b0, irq)
  endtask
  task automatic t_out;
    do_reset();
    ahb(`UEFS_ADDR_CFG, 1'b1, 32'h0000_1102);
    host_u.send_out(8'h30, 4, 1'b0);
    st(1);
    `CHK("out busy", 2'd1, r[13:12])
    `CHK("out tog", 2'b00, r[9:8])
    `CHK("out count", 7'd4, r[26:20])
    `CHK("out data", 1'b1, r[16])
    `CHK("irq full", 1'b1, irq)
    ahb(`UEFS_ADDR_DATA, 1'b0, 32'h0);
    `CHK("out byte", 8'h30, r[7:0])
    st(1);
    `CHK("out left", 7'd3, r[26:20])
    host_u.fault(1'b1);
    st(2);
    `CHK("err flag", 1'b0, r[16])
    host_u.fault(1'b0);
    ahb(`UEFS_ADDR_SET, 1'b1, 32'h0000_00ff);
    st(1);
    `CHK("iso set", 8'he7, r[7:0])
    ahb(`UEFS_ADDR_CLR, 1'b1, 32'h0000_0004);
    st(1);
    `CHK("iso clr", 8'he3, r[7:0])
  endtask
  task automatic summarize;
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, rst_n} = '0;
    t_regs();
    t_in();
    t_force();
    t_out();
    summarize();
  end
  // watchdog: far beyond the under two hundred cycles the scenarios need
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
endmodule
